// ==== core/i2cshb_pkg.sv ====
// Package with constants, carrier structs and state types of the I2C slave engine.
package i2cshb_pkg;

  localparam int I2CSHB_BYTE_BITS = 8;
  localparam logic [3:0] I2CSHB_CNT_BYTE = 4'h8;
  localparam logic [3:0] I2CSHB_CNT_ZERO = 4'h0;
  localparam logic [4:0] I2CSHB_TEN_HIGH = 5'h1E;
  localparam logic [7:0] I2CSHB_OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] I2CSHB_BYTE_RST = 8'h00;
  localparam logic I2CSHB_CLK_REL_RST = 1'b1;

  typedef enum logic [2:0] {
    I2CSHB_IDLE,
    I2CSHB_ADDR,
    I2CSHB_RX,
    I2CSHB_ACK,
    I2CSHB_TX
  } i2cshb_phase_t;

  typedef struct packed {
    logic address_hold_enable;
    logic data_hold_enable;
    logic stretch_enable;
    logic slave_collision_detect_en;
    logic ten_bit_mode;
    logic ack_value_out;
  } i2cshb_cfg_t;

  typedef struct packed {
    logic irq_clear;
    logic release_set;
    logic buf_read;
    logic buf_write;
    logic addr_write;
    logic overflow_clear;
    logic collision_clear;
    logic [7:0] wdata;
  } i2cshb_sw_t;

  typedef struct packed {
    logic port_irq_flag;
    logic clock_release;
    logic ack_time_flag;
    logic buffer_full;
    logic receive_overflow;
    logic ack_received;
    logic bus_collision_flag;
    logic addr_refresh_flag;
    logic read_status;
    logic data_status;
    logic start_seen;
    logic stop_seen;
    logic [7:0] transfer_buffer;
    logic [7:0] own_address_reg;
  } i2cshb_status_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    i2cshb_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] rx_shift;
    logic [7:0] shift_register;
    logic is_addr;
    logic hold_byte;
    logic nack;
    logic high_write;
    logic low_byte;
    logic ten_low_next;
    logic ten_full;
    logic sda_drive;
    logic scl_hold;
    i2cshb_status_t st;
  } i2cshb_state_t;

endpackage

// ==== core/i2cshb_slave.sv ====
// I2C slave engine with address/data hold, slave transmit and 10-bit addressing.
// Notes on behaviour
// - With a hold enabled, flag set and clock released bit cleared after 8th fall.
// - Ack time flag shows whether the flag came before or after the ack slot.
// - In hold modes the ack slot drives the level software wrote.
// - Reading the receive buffer clears buffer full.
// - Flag set after 9th fall whenever an ack was sent, never after a nack.
// - With stretching enabled, SCL held after each received byte's ack.
// - Reception ends on a sent nack or a Stop; Stop is kept as status.
// - Matching read address sets read status, loads buffer, acks on 9th bit.
// - After acking a read, clock release cleared and SCL held.
// - Transmit write loads shift register; bits leave MSB first on falling SCL.
// - Master ack sampled on 9th rise; nack sends the engine idle.
// - In transmit the flag is set on each 9th falling edge.
// - Collision while sending with detection enabled sets collision flag and goes idle.
// - After a sent byte, stretch on master ack, release on nack, flag anyway.
// - Address hold on read address: release cleared and flag raised before ack.
// - Address hold read: again cleared and flagged after ack, stretched until data.
// - 10-bit high write address match sets address refresh flag, acks, flags.
// - Writes of own address register clear the address refresh flag; SCL stays held if clock release is cleared.
// - 10-bit data reception with stretching clears release after each byte.
// - 10-bit first byte compares against 11110, two upper bits, then zero unless the full 10-bit address already matched.
// - No ack for a byte arriving while buffer full or overflow is set.
// - Without any hold the ack is generated by hardware.
// - 7-bit matching ignores the low bit of the address byte.
`timescale 1ns/1ps
module i2cshb_slave (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire i2cshb_pkg::i2cshb_cfg_t cfg,
  input wire i2cshb_pkg::i2cshb_sw_t sw,
  output i2cshb_pkg::i2cshb_status_t status
);
  import i2cshb_pkg::*;

  i2cshb_state_t r;
  i2cshb_state_t next_r;
  logic fall;
  logic rise;
  logic start_cond;
  logic stop_cond;
  logic match;
  logic hi_match;
  logic [7:0] b;

  assign fall = r.scl_d & ~r.scl_s2;
  assign rise = ~r.scl_d & r.scl_s2;
  assign start_cond = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
  assign stop_cond = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
  assign b = r.rx_shift;
  assign hi_match = (b[7:3] == I2CSHB_TEN_HIGH) && (b[2:1] == r.st.own_address_reg[2:1]);

  always_comb begin
    if (cfg.ten_bit_mode) begin
      if (r.ten_low_next) begin
        match = (b == r.st.own_address_reg);
      end else begin
        match = hi_match && (!b[0] || r.ten_full);
      end
    end else begin
      match = (b[7:1] == r.st.own_address_reg[7:1]);
    end
  end

  always_comb begin
    next_r = r;
    next_r.scl_s1 = scl_in;
    next_r.scl_s2 = r.scl_s1;
    next_r.scl_d = r.scl_s2;
    next_r.sda_s1 = sda_in;
    next_r.sda_s2 = r.sda_s1;
    next_r.sda_d = r.sda_s2;

    // Software clears come first so that a hardware set in the same cycle wins.
    if (sw.irq_clear) begin
      next_r.st.port_irq_flag = 1'b0;
    end
    if (sw.release_set) begin
      next_r.st.clock_release = 1'b1;
    end
    if (sw.buf_read) begin
      next_r.st.buffer_full = 1'b0;
    end
    if (sw.overflow_clear) begin
      next_r.st.receive_overflow = 1'b0;
    end
    if (sw.collision_clear) begin
      next_r.st.bus_collision_flag = 1'b0;
    end
    if (sw.addr_write) begin
      next_r.st.own_address_reg = sw.wdata;
      next_r.st.addr_refresh_flag = 1'b0;
    end
    if (sw.buf_write) begin
      next_r.st.transfer_buffer = sw.wdata;
      next_r.shift_register = sw.wdata;
      next_r.st.buffer_full = 1'b1;
    end

    if (start_cond) begin
      next_r.phase = I2CSHB_ADDR;
      next_r.cnt = I2CSHB_CNT_ZERO;
      next_r.st.start_seen = 1'b1;
      next_r.st.stop_seen = 1'b0;
      next_r.st.ack_time_flag = 1'b0;
      next_r.ten_low_next = 1'b0;
    end else if (stop_cond) begin
      next_r.phase = I2CSHB_IDLE;
      next_r.st.stop_seen = 1'b1;
      next_r.st.start_seen = 1'b0;
      next_r.st.ack_time_flag = 1'b0;
      next_r.ten_low_next = 1'b0;
      next_r.ten_full = 1'b0;
    end else begin
      case (r.phase)
        I2CSHB_ADDR, I2CSHB_RX: begin
          // Bits are counted on rises so the SCL fall that closes a Start is not a bit.
          if (rise && r.cnt < I2CSHB_CNT_BYTE) begin
            next_r.rx_shift = {r.rx_shift[6:0], r.sda_s2};
            next_r.cnt = r.cnt + 4'h1;
          end
          if (fall) begin
            if (r.cnt == I2CSHB_CNT_BYTE) begin
              next_r.cnt = I2CSHB_CNT_BYTE;
              if (r.phase == I2CSHB_ADDR && !match) begin
                next_r.phase = I2CSHB_IDLE;
                if (cfg.ten_bit_mode && r.ten_low_next) begin
                  next_r.st.addr_refresh_flag = 1'b1;
                  next_r.st.port_irq_flag = 1'b1;
                end
              end else begin
                next_r.phase = I2CSHB_ACK;
                next_r.is_addr = (r.phase == I2CSHB_ADDR);
                next_r.low_byte = r.ten_low_next;
                next_r.high_write = cfg.ten_bit_mode && !r.ten_low_next && !b[0];
                next_r.nack = r.st.buffer_full | r.st.receive_overflow;
                next_r.st.data_status = (r.phase == I2CSHB_RX);
                if (r.phase == I2CSHB_ADDR) begin
                  next_r.st.read_status = r.ten_low_next ? 1'b0 : b[0];
                end
                if (r.st.buffer_full) begin
                  next_r.st.receive_overflow = 1'b1;
                end else begin
                  next_r.st.transfer_buffer = b;
                  next_r.st.buffer_full = 1'b1;
                end
                next_r.hold_byte = (r.phase == I2CSHB_ADDR) ? cfg.address_hold_enable :
                                   cfg.data_hold_enable;
                if (next_r.hold_byte) begin
                  next_r.st.port_irq_flag = 1'b1;
                  next_r.st.clock_release = 1'b0;
                  next_r.st.ack_time_flag = 1'b1;
                end
              end
            end
          end
        end
        I2CSHB_ACK: begin
          if (fall) begin
            next_r.st.ack_time_flag = 1'b0;
            next_r.cnt = I2CSHB_CNT_ZERO;
            if (r.sda_drive) begin
              next_r.st.port_irq_flag = 1'b1;
              if (r.is_addr && r.high_write) begin
                next_r.st.addr_refresh_flag = 1'b1;
                next_r.ten_low_next = 1'b1;
                next_r.phase = I2CSHB_ADDR;
              end else if (r.is_addr && r.st.read_status) begin
                next_r.st.clock_release = 1'b0;
                next_r.phase = I2CSHB_TX;
              end else begin
                if (r.low_byte) begin
                  next_r.ten_full = 1'b1;
                  next_r.ten_low_next = 1'b0;
                  next_r.st.addr_refresh_flag = 1'b1;
                end
                if (cfg.stretch_enable) begin
                  next_r.st.clock_release = 1'b0;
                end
                next_r.phase = I2CSHB_RX;
              end
            end else begin
              next_r.phase = I2CSHB_IDLE;
            end
          end
        end
        I2CSHB_TX: begin
          if (rise && r.cnt < I2CSHB_CNT_BYTE && !r.sda_drive && !r.sda_s2 &&
              cfg.slave_collision_detect_en) begin
            next_r.st.bus_collision_flag = 1'b1;
            next_r.phase = I2CSHB_IDLE;
          end else if (rise && r.cnt == I2CSHB_CNT_BYTE) begin
            next_r.st.ack_received = r.sda_s2;
          end else if (fall) begin
            if (r.cnt < I2CSHB_CNT_BYTE) begin
              next_r.shift_register = {r.shift_register[6:0], 1'b0};
              next_r.cnt = r.cnt + 4'h1;
            end else begin
              next_r.st.port_irq_flag = 1'b1;
              next_r.st.buffer_full = 1'b0;
              next_r.cnt = I2CSHB_CNT_ZERO;
              if (r.st.ack_received) begin
                next_r.phase = I2CSHB_IDLE;
              end else begin
                next_r.st.clock_release = 1'b0;
              end
            end
          end
        end
        I2CSHB_IDLE: begin
          next_r.cnt = I2CSHB_CNT_ZERO;
        end
        default: begin
          next_r.phase = I2CSHB_IDLE;
        end
      endcase
    end

    // Ack level: hardware ack without hold, software level with hold, never when full.
    next_r.sda_drive = 1'b0;
    if (next_r.phase == I2CSHB_ACK) begin
      next_r.sda_drive = !next_r.nack && (!next_r.hold_byte || !cfg.ack_value_out);
    end else if (next_r.phase == I2CSHB_TX && next_r.cnt < I2CSHB_CNT_BYTE) begin
      next_r.sda_drive = !next_r.shift_register[7];
    end
    // SCL is only grabbed once it is already low, so the high time is never cut short.
    next_r.scl_hold = (!next_r.st.clock_release || next_r.st.addr_refresh_flag) &&
                      (!r.scl_s2 || r.scl_hold);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_d <= 1'b1;
      r.phase <= I2CSHB_IDLE;
      r.rx_shift <= I2CSHB_BYTE_RST;
      r.shift_register <= I2CSHB_BYTE_RST;
      r.st.clock_release <= I2CSHB_CLK_REL_RST;
      r.st.transfer_buffer <= I2CSHB_BYTE_RST;
      r.st.own_address_reg <= I2CSHB_OWN_ADDR_RST;
    end else begin
      r <= next_r;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = r.scl_hold;
  assign sda_oe = r.sda_drive;
  assign status = r.st;

endmodule

// ==== tb/i2cshb_slave_props.sv ====
// Concurrent checks on the ports of the I2C slave engine.
`timescale 1ns/1ps
module i2cshb_slave_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire i2cshb_pkg::i2cshb_cfg_t cfg,
  input wire i2cshb_pkg::i2cshb_sw_t sw,
  input wire i2cshb_pkg::i2cshb_status_t status
);
  import i2cshb_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_held;
    !status.clock_release ##1 scl_oe;
  endsequence
  sequence s_freed;
    status.clock_release ##1 !scl_oe;
  endsequence
  a_ack_hold: assert property (
    $rose(status.ack_time_flag) |-> status.port_irq_flag && !status.clock_release)
    else $error("ack time flag without a held flag");
  a_stretch_held: assert property ($fell(status.clock_release) |-> s_held)
    else $error("clock release cleared but SCL not held");
  a_release_frees: assert property (
    sw.release_set && !status.addr_refresh_flag |=> s_freed)
    else $error("release strobe did not free SCL");
  a_hold_low: assert property ($rose(scl_oe) |-> !$past(scl_in, 3))
    else $error("SCL pulled while it was high");
  a_buf_read: assert property (
    sw.buf_read && !sw.buf_write |=> !status.buffer_full || sda_oe)
    else $error("buffer read left buffer full");
  a_buf_write: assert property (
    sw.buf_write |=> status.transfer_buffer == $past(sw.wdata) && status.buffer_full)
    else $error("transmit write not loaded");
  a_addr_write: assert property (
    sw.addr_write |=> status.own_address_reg == $past(sw.wdata) && !status.addr_refresh_flag)
    else $error("own address write not taken");
  a_sda_stable: assert property (
    $changed(sda_oe) |-> !$past(scl_in) || status.bus_collision_flag)
    else $error("SDA drive changed while SCL high");
  a_ack_sample: assert property ($changed(status.ack_received) |-> $past(scl_in))
    else $error("ack received changed while SCL low");
endmodule
bind i2cshb_slave i2cshb_slave_props u_props (.clk_sys(clk_sys), .reset(reset),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .cfg(cfg), .sw(sw), .status(status));

// ==== tb/i2cshb_master.sv ====
// Behavioural I2C bus master that pulls SCL and SDA low as open drain.
`timescale 1ns/1ps
module i2cshb_master (
  input wire logic clk_sys,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low,
  output logic stuck
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck = 1'b0;
  end
  task automatic half();
    repeat (16) @(posedge clk_sys);
  endtask
  // Releases SCL and waits while the slave stretches it.
  task automatic rise();
    int n;
    n = 0;
    scl_low <= 1'b0;
    @(posedge clk_sys);
    while (scl !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 4000) stuck <= 1'b1;
    half();
  endtask
  task automatic start();
    sda_low <= 1'b0;
    half();
    rise();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
    half();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    half();
    rise();
    sda_low <= 1'b0;
    half();
  endtask
  // Sends d MSB first and a in the ack slot; r holds the nine sampled levels.
  task automatic xfer(input logic [7:0] d, input logic a, output logic [8:0] r);
    logic [8:0] v;
    v = {d, a};
    for (int i = 8; i >= 0; i--) begin
      sda_low <= !v[i];
      half();
      rise();
      r[i] = sda;
      scl_low <= 1'b1;
      half();
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the I2C slave engine.
`timescale 1ns/1ps
module tb_top;
  import i2cshb_pkg::*;
  logic clk_sys, reset, scl_in, sda_in, scl_out, sda_out, scl_oe, sda_oe;
  logic m_scl, m_sda, stuck;
  i2cshb_cfg_t cfg;
  i2cshb_sw_t sw;
  i2cshb_status_t st;
  logic [8:0] r;
  int failures;
  int cmp_count;
  logic [8:0] rows [3] = '{{8'hA4, 1'b0}, {8'hA6, 1'b1}, {8'h24, 1'b1}};
  assign scl_in = !(m_scl || scl_oe);
  assign sda_in = !(m_sda || sda_oe);
  i2cshb_slave dut (.clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg),
    .sw(sw), .status(st));
  i2cshb_master m (.clk_sys(clk_sys), .scl(scl_in), .sda(sda_in), .scl_low(m_scl),
    .sda_low(m_sda), .stuck(stuck));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(input logic [6:0] f, input logic [7:0] d);
    sw <= {f, d};
    @(posedge clk_sys);
    sw <= '0;
    @(posedge clk_sys);
  endtask
  // Waits for the held clock, checks the flags, then services and releases.
  task automatic svc(input logic [2:0] e);
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    chk("hold wait", 0, n == 500);
    chk("hold flags", e, {st.port_irq_flag, st.clock_release, st.ack_time_flag});
    pulse(7'h50, 8'h00);
    pulse(7'h20, 8'h00);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    close_out();
  end
  initial begin
    reset = 1'b1;
    cfg = '0;
    sw = '0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("reset status", 28'h4000000, st);
    chk("reset pins", 0, {scl_oe, sda_oe});
    pulse(7'h04, 8'hA5);
    foreach (rows[i]) begin
      m.start();
      m.xfer(rows[i][8:1], 1'b1, r);
      chk("addr ack", rows[i][0], r[0]);
      if (!rows[i][0]) begin
        chk("addr load", {2'b11, rows[i][8:1]}, {st.port_irq_flag, st.buffer_full, st.transfer_buffer});
        pulse(7'h50, 8'h00);
        chk("buf read", 0, st.buffer_full);
        m.xfer(~rows[i][8:1], 1'b1, r);
        chk("data", {1'b0, ~rows[i][8:1], 1'b1}, {r[0], st.transfer_buffer, st.port_irq_flag});
        pulse(7'h50, 8'h00);
      end
      m.stop();
      chk("stop", 1, st.stop_seen);
      $display("test row %0d done", i);
    end
    m.start();
    m.xfer(8'hA4, 1'b1, r);
    m.xfer(8'h11, 1'b1, r);
    chk("overflow", 3'b111, {r[0], st.receive_overflow, st.transfer_buffer == 8'hA4});
    m.stop();
    pulse(7'h12, 8'h00);
    chk("overflow clear", 0, {st.receive_overflow, st.buffer_full});
    $display("test overflow done");
    cfg <= 6'b110000;
    pulse(7'h40, 8'h00);
    m.start();
    fork
      m.xfer(8'hA4, 1'b1, r);
      svc(3'b101);
    join
    chk("hold ack", 3'b010, {r[0], st.port_irq_flag, st.ack_time_flag});
    cfg.ack_value_out <= 1'b1;
    pulse(7'h40, 8'h00);
    fork
      m.xfer(8'h77, 1'b1, r);
      svc(3'b101);
    join
    chk("hold nack", 2'b10, {r[0], st.port_irq_flag});
    m.stop();
    pulse(7'h10, 8'h00);
    $display("test hold done");
    cfg <= 6'b000100;
    m.start();
    m.xfer(8'hA5, 1'b1, r);
    chk("read addr", 5'b01011, {r[0], st.read_status, st.clock_release, scl_oe, st.buffer_full});
    pulse(7'h50, 8'h00);
    for (int k = 0; k < 2; k++) begin
      pulse(7'h48, k ? 8'h3C : 8'h96);
      pulse(7'h20, 8'h00);
      m.xfer(8'hFF, k[0], r);
      chk("tx byte", {k ? 8'h3C : 8'h96, k[0], 1'b1, !k[0], !k[0]},
        {r[8:1], st.ack_received, st.port_irq_flag, !st.clock_release, scl_oe});
    end
    m.stop();
    $display("test transmit done");
    m.start();
    m.xfer(8'hA5, 1'b1, r);
    pulse(7'h50, 8'h00);
    pulse(7'h48, 8'hFF);
    pulse(7'h20, 8'h00);
    m.xfer(8'h00, 1'b1, r);
    chk("collision", 2'b10, {st.bus_collision_flag, sda_oe});
    m.stop();
    pulse(7'h11, 8'h00);
    $display("test collision done");
    cfg <= 6'b000010;
    pulse(7'h44, 8'h06);
    m.start();
    m.xfer(8'hF6, 1'b1, r);
    chk("ten high", 4'b0111, {r[0], st.addr_refresh_flag, scl_oe, st.port_irq_flag});
    pulse(7'h54, 8'h5A);
    m.xfer(8'h5A, 1'b1, r);
    chk("ten low", 3'b011, {r[0], st.addr_refresh_flag, st.port_irq_flag});
    pulse(7'h54, 8'h06);
    m.xfer(8'h33, 1'b1, r);
    chk("ten data", 9'h033, {r[0], st.transfer_buffer});
    m.stop();
    $display("test ten bit done");
    chk("master stuck", 0, stuck);
    close_out();
  end
endmodule
